// ---- logic/pdcb_pkg.sv ----
/*
  Constants, field layout and enumerations for the DSP and line-driver
  configuration bank of a 10/100 PHY.
  Assumes a single 200 MHz clock and a plain management register port
  that carries the extended register addresses.
*/
`default_nettype none

package pdcb_pkg;

  typedef logic [15:0] pdcb_word_t;

  localparam int unsigned PDCB_NREG = 6;

  // Register addresses, register indices.
  localparam pdcb_word_t PDCB_OFS_LVL_A = 16'h030b;
  localparam pdcb_word_t PDCB_OFS_LVL_B = 16'h030c;
  localparam pdcb_word_t PDCB_OFS_SWEEP = 16'h030f;
  localparam pdcb_word_t PDCB_OFS_GAIN  = 16'h0311;
  localparam pdcb_word_t PDCB_OFS_COEFF = 16'h0313;
  localparam pdcb_word_t PDCB_OFS_TLOOP = 16'h031c;

  localparam int PDCB_IDX_LVL_A = 0;
  localparam int PDCB_IDX_LVL_B = 1;
  localparam int PDCB_IDX_SWEEP = 2;
  localparam int PDCB_IDX_GAIN  = 3;
  localparam int PDCB_IDX_COEFF = 4;
  localparam int PDCB_IDX_TLOOP = 5;

  localparam logic [PDCB_NREG-1:0][15:0] PDCB_OFS_ALL = {
    PDCB_OFS_TLOOP, PDCB_OFS_COEFF, PDCB_OFS_GAIN,
    PDCB_OFS_SWEEP, PDCB_OFS_LVL_B, PDCB_OFS_LVL_A};

  // Reset values.
  localparam logic [PDCB_NREG-1:0][15:0] PDCB_RST_ALL = {
    16'h1101, 16'h06f8, 16'h01fc, 16'h0464, 16'h0020, 16'h0c00};

  // Writable bits; everything else is reserved and reads as zero.
  localparam logic [PDCB_NREG-1:0][15:0] PDCB_MASK_ALL = {
    16'hffff, 16'hffff, 16'he1fe, 16'h07ff, 16'h003f, 16'h0fff};

  // Field positions.
  localparam int PDCB_MINUS_LSB   = 6;
  localparam int PDCB_ZERO_LSB    = 0;
  localparam int PDCB_PLUS_LSB    = 0;
  localparam int PDCB_TIMER_LSB   = 8;
  localparam int PDCB_HOLD1_BIT   = 7;
  localparam int PDCB_HOLD2_BIT   = 6;
  localparam int PDCB_HOLD3_BIT   = 5;
  localparam int PDCB_CHK_LSB     = 2;
  localparam int PDCB_FACC_BIT    = 1;
  localparam int PDCB_DFERST_BIT  = 0;
  localparam int PDCB_GMAP_LSB    = 14;
  localparam int PDCB_CSEL_BIT    = 13;
  localparam int PDCB_C0S_LSB     = 1;
  localparam int PDCB_C0L_LSB     = 8;
  localparam int PDCB_C1S_LSB     = 0;
  localparam int PDCB_KPON_BIT    = 15;
  localparam int PDCB_KFON_BIT    = 14;
  localparam int PDCB_KPVAL_LSB   = 11;
  localparam int PDCB_KFVAL_LSB   = 7;
  localparam int PDCB_KPHON_BIT   = 6;
  localparam int PDCB_KPHVAL_BIT  = 5;
  localparam int PDCB_KFHON_BIT   = 4;
  localparam int PDCB_KFHVAL_BIT  = 3;
  localparam int PDCB_TEDPOL_BIT  = 2;
  localparam int PDCB_ESEL_BIT    = 1;
  localparam int PDCB_PREEN_BIT   = 0;

  // Metric check index within the three-bit enable field.
  localparam int PDCB_CHK_DFE = 0;
  localparam int PDCB_CHK_MSE = 1;
  localparam int PDCB_CHK_PRE = 2;

  localparam logic [1:0] PDCB_GMAP_BAD = 2'h3;
  localparam logic [1:0] PDCB_GMAP_DEF = 2'h0;

  typedef enum logic [1:0] {
    PDCB_SYM_ZERO  = 2'b00,
    PDCB_SYM_PLUS  = 2'b01,
    PDCB_SYM_IDLE  = 2'b10,
    PDCB_SYM_MINUS = 2'b11
  } pdcb_sym_e;

  typedef enum logic [1:0] {
    PDCB_FFE_OTHER = 2'b00,
    PDCB_FFE_ST1   = 2'b01,
    PDCB_FFE_ST2   = 2'b10,
    PDCB_FFE_ST3   = 2'b11
  } pdcb_ffe_e;

  typedef enum logic [1:0] {
    PDCB_CAB_SHORT = 2'b00,
    PDCB_CAB_MID   = 2'b01,
    PDCB_CAB_LONG  = 2'b10,
    PDCB_CAB_NONE  = 2'b11
  } pdcb_cable_e;

endpackage : pdcb_pkg

`default_nettype wire

// ---- logic/pdcb_reg_if.sv ----
/*
  Carrier between the bank's control logic and its register store.
  Assumes the control side decodes addresses into one-hot write selects.
*/
`default_nettype none

interface pdcb_reg_if
  import pdcb_pkg::*;
  ();
  logic [PDCB_NREG-1:0]       wr_sel;
  pdcb_word_t                 wdata;
  logic [PDCB_NREG-1:0][15:0] q;

  modport store (input wr_sel, input wdata, output q);
  modport ctrl  (output wr_sel, output wdata, input q);
endinterface : pdcb_reg_if

`default_nettype wire

// ---- logic/pdcb_reg_store.sv ----
/*
  Storage for the six configuration words, with reserved bits masked.
  Assumes at most one write select is high per cycle.
*/
`default_nettype none

module pdcb_reg_store
  import pdcb_pkg::*;
  (
  // Clock and reset.
  input wire logic  clk,
  input wire logic  reset_n,
  // Register carrier.
  pdcb_reg_if.store rif
  );

  always_ff @(posedge clk) begin
    for (int i = 0; i < PDCB_NREG; i++) begin
      if (!reset_n) begin
        rif.q[i] <= PDCB_RST_ALL[i];
      end else if (rif.wr_sel[i]) begin
        rif.q[i] <= rif.wdata & PDCB_MASK_ALL[i];
      end
    end
  end

  reserved_zero_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    rif.wr_sel[PDCB_IDX_LVL_B] |=>
      (rif.q[PDCB_IDX_LVL_B] & ~PDCB_MASK_ALL[PDCB_IDX_LVL_B]) == 16'h0000)
    else $error("reserved bits stored a written one");

endmodule : pdcb_reg_store

`default_nettype wire

// ---- logic/pdcb_top.sv ----
/*
  DSP and line-driver configuration bank: management register port,
  readback, and the registered control outputs that steer the line
  driver, the feed-forward equalizer sequence, the sweep and the timing
  loop.
  Assumes management accesses are synchronous to clk and that the DSP
  supplies its symbol, sequence state, cable class and adapted values.
*/
// Functional notes
// - Minus-one and zero drive codes come from fields 11-6 and 5-0.
// - Plus-one drive code comes from bits 5-0 of second level reg.
// - First feed-forward state duration uses timer select bits 10-8.
// - Each feed-forward state holds its equalizer while its bit is one.
// - Sweep metric checks run only when their enable bit is set.
// - Bit 1 clears frequency accumulator on each sweep iteration.
// - Bit 0 resets feedback equalizer coefficients each iteration.
// - Two-bit field picks one of exactly three gain combinations.
// - Bit 13 selects least-squares set, else low pre-cursor set.
// - Short cables force coefficient 0 from bits 8-1.
// - Long cables force coefficient 0 from bits 15-8.
// - Short cables force coefficient 1 from bits 7-0.
// - Bit 15 overrides proportional gain with bits 13-11.
// - Bit 14 overrides integral gain with bits 10-7.
// - With bit 6 set, bit 5 freezes or unfreezes proportional arm.
// - With bit 4 set, bit 3 freezes or unfreezes integral arm.
// - Energy input is slicer input, or DC-free converter when bit set.
// - Pre-cursor metric is computed only while its enable bit is set.
`default_nettype none

module pdcb_top
  import pdcb_pkg::*;
  (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Management register port.
  input  wire logic       mgmt_wr_en,
  input  wire logic       mgmt_rd_en,
  input  wire logic [15:0] mgmt_addr,
  input  wire logic [15:0] mgmt_wdata,
  output var  logic [15:0] mgmt_rdata_r,
  output var  logic       mgmt_rd_valid_r,
  // Line driver.
  input  wire pdcb_sym_e  tx_symbol,
  output var  logic [5:0] line_drive_code_r,
  // Feed-forward equalizer sequence.
  input  wire pdcb_ffe_e  ffe_state,
  output var  logic [2:0] first_ffwd_state_timer_r,
  output var  logic       ffwd_hold_r,
  // Equalization sweep.
  input  wire logic       sweep_active,
  input  wire logic       sweep_iter,
  output var  logic       chk_dfe_en_r,
  output var  logic       chk_mse_en_r,
  output var  logic       chk_pre_en_r,
  output var  logic       freqacc_clear_r,
  output var  logic       dfe_coeff_reset_r,
  // Gain and coefficient selection.
  input  wire pdcb_cable_e cable_class,
  output var  logic [1:0] gain_map_sel_r,
  output var  logic       coeff_set_ls_r,
  output var  logic [7:0] coeff0_force_r,
  output var  logic       coeff0_force_valid_r,
  output var  logic [7:0] coeff1_force_r,
  output var  logic       coeff1_force_valid_r,
  // Timing loop.
  input  wire logic [2:0] adapted_kp,
  input  wire logic [3:0] adapted_kf,
  input  wire logic       adapted_prop_hold,
  input  wire logic       adapted_integ_hold,
  output var  logic [2:0] eff_kp_r,
  output var  logic [3:0] eff_kf_r,
  output var  logic       prop_arm_hold_r,
  output var  logic       integ_arm_hold_r,
  output var  logic       ted_pol_invert_r,
  output var  logic       precursor_metric_en_r,
  // Energy detect.
  input  wire logic [9:0] slicer_in,
  input  wire logic [9:0] adc_dc_free,
  output var  logic [9:0] energy_in_r
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // A forced hold bit wins over the adapted hold only while its enable is on.
  function automatic logic arm_hold(input logic on, input logic val,
                                    input logic adapted);
    arm_hold = on ? val : adapted;
  endfunction : arm_hold

  pdcb_reg_if rif ();

  pdcb_reg_store u_store (
    .clk     (clk),
    .reset_n (reset_n),
    .rif     (rif)
  );

  // Address decode.
  logic [PDCB_NREG-1:0] addr_hit;
  logic [15:0]          rd_word;

  always_comb begin
    for (int i = 0; i < PDCB_NREG; i++) begin
      addr_hit[i] = (mgmt_addr == PDCB_OFS_ALL[i]);
    end
  end

  assign rif.wr_sel = mgmt_wr_en ? addr_hit : '0;
  assign rif.wdata  = mgmt_wdata;

  // Unmapped addresses read back as zero.
  always_comb begin
    rd_word = 16'h0000;
    for (int i = 0; i < PDCB_NREG; i++) begin
      if (addr_hit[i]) begin
        rd_word = rif.q[i] & PDCB_MASK_ALL[i];
      end
    end
  end

  // Field views.
  pdcb_word_t reg_a, reg_b, reg_sw, reg_g, reg_c, reg_t;
  assign reg_a  = rif.q[PDCB_IDX_LVL_A];
  assign reg_b  = rif.q[PDCB_IDX_LVL_B];
  assign reg_sw = rif.q[PDCB_IDX_SWEEP];
  assign reg_g  = rif.q[PDCB_IDX_GAIN];
  assign reg_c  = rif.q[PDCB_IDX_COEFF];
  assign reg_t  = rif.q[PDCB_IDX_TLOOP];

  logic [5:0] minus_code, zero_code, plus_code;
  logic [2:0] ffwd_timer;
  logic       ffwd_state1_hold, ffwd_state2_hold, ffwd_state3_hold;
  logic [2:0] chk_en;
  logic       freqacc_clr_on, dfe_reset_on;
  logic [1:0] gain_map_raw;
  logic       coeff_ls_on;
  logic [7:0] c0_short, c0_long, c1_short;
  logic       prop_gain_override_on, integ_gain_override_on;
  logic [2:0] prop_gain_override_value;
  logic [3:0] integ_gain_override_value;
  logic       prop_arm_hold_on, prop_arm_hold_value;
  logic       integ_arm_hold_on, integ_arm_hold_value;
  logic       energy_adc_on, precursor_on, ted_pol_on;

  assign minus_code = reg_a[PDCB_MINUS_LSB +: 6];
  assign zero_code  = reg_a[PDCB_ZERO_LSB +: 6];
  assign plus_code  = reg_b[PDCB_PLUS_LSB +: 6];
  assign ffwd_timer = reg_sw[PDCB_TIMER_LSB +: 3];
  assign ffwd_state1_hold = reg_sw[PDCB_HOLD1_BIT];
  assign ffwd_state2_hold = reg_sw[PDCB_HOLD2_BIT];
  assign ffwd_state3_hold = reg_sw[PDCB_HOLD3_BIT];
  assign chk_en         = reg_sw[PDCB_CHK_LSB +: 3];
  assign freqacc_clr_on = reg_sw[PDCB_FACC_BIT];
  assign dfe_reset_on   = reg_sw[PDCB_DFERST_BIT];
  assign gain_map_raw   = reg_g[PDCB_GMAP_LSB +: 2];
  assign coeff_ls_on    = reg_g[PDCB_CSEL_BIT];
  assign c0_short       = reg_g[PDCB_C0S_LSB +: 8];
  assign c0_long        = reg_c[PDCB_C0L_LSB +: 8];
  assign c1_short       = reg_c[PDCB_C1S_LSB +: 8];
  assign prop_gain_override_on     = reg_t[PDCB_KPON_BIT];
  assign integ_gain_override_on    = reg_t[PDCB_KFON_BIT];
  assign prop_gain_override_value  = reg_t[PDCB_KPVAL_LSB +: 3];
  assign integ_gain_override_value = reg_t[PDCB_KFVAL_LSB +: 4];
  assign prop_arm_hold_on     = reg_t[PDCB_KPHON_BIT];
  assign prop_arm_hold_value  = reg_t[PDCB_KPHVAL_BIT];
  assign integ_arm_hold_on    = reg_t[PDCB_KFHON_BIT];
  assign integ_arm_hold_value = reg_t[PDCB_KFHVAL_BIT];
  assign ted_pol_on    = reg_t[PDCB_TEDPOL_BIT];
  assign energy_adc_on = reg_t[PDCB_ESEL_BIT];
  assign precursor_on  = reg_t[PDCB_PREEN_BIT];

  // Next values of the control outputs.
  logic [5:0] drive_nxt;
  logic       hold_nxt;
  logic [1:0] gain_map_nxt;
  logic [7:0] c0_nxt;
  logic       c0_valid_nxt;
  logic       c1_valid_nxt;
  logic [2:0] kp_nxt;
  logic [3:0] kf_nxt;
  logic [9:0] energy_nxt;

  // The idle symbol drives the zero level so the line rests at mid scale.
  assign drive_nxt = (tx_symbol == PDCB_SYM_MINUS) ? minus_code :
                     (tx_symbol == PDCB_SYM_PLUS)  ? plus_code  :
                     zero_code;

  always_comb begin
    case (ffe_state)
      PDCB_FFE_ST1: hold_nxt = ffwd_state1_hold;
      PDCB_FFE_ST2: hold_nxt = ffwd_state2_hold;
      PDCB_FFE_ST3: hold_nxt = ffwd_state3_hold;
      default:      hold_nxt = 1'b0;
    endcase
  end

  // A code of three has no gain combination behind it; the default is used.
  assign gain_map_nxt = (gain_map_raw == PDCB_GMAP_BAD) ?
                        PDCB_GMAP_DEF : gain_map_raw;

  assign c0_nxt = (cable_class == PDCB_CAB_LONG) ?
                  c0_long : c0_short;
  assign c0_valid_nxt = (cable_class == PDCB_CAB_SHORT) ||
                        (cable_class == PDCB_CAB_LONG);
  assign c1_valid_nxt = (cable_class == PDCB_CAB_SHORT);

  assign kp_nxt = prop_gain_override_on  ? prop_gain_override_value
                                         : adapted_kp;
  assign kf_nxt = integ_gain_override_on ? integ_gain_override_value
                                         : adapted_kf;

  assign energy_nxt = energy_adc_on ? adc_dc_free : slicer_in;

  // Management answer.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mgmt_rdata_r    <= 16'h0000;
      mgmt_rd_valid_r <= 1'b0;
    end else begin
      mgmt_rd_valid_r <= mgmt_rd_en;
      if (mgmt_rd_en) begin
        mgmt_rdata_r <= rd_word;
      end
    end
  end

  // Line driver, sequence and sweep controls.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      line_drive_code_r        <= 6'h00;
      first_ffwd_state_timer_r <= 3'h0;
      ffwd_hold_r              <= 1'b0;
      chk_dfe_en_r             <= 1'b0;
      chk_mse_en_r             <= 1'b0;
      chk_pre_en_r             <= 1'b0;
      freqacc_clear_r          <= 1'b0;
      dfe_coeff_reset_r        <= 1'b0;
    end else begin
      line_drive_code_r        <= drive_nxt;
      first_ffwd_state_timer_r <= ffwd_timer;
      ffwd_hold_r              <= hold_nxt;
      chk_dfe_en_r <= sweep_active & chk_en[PDCB_CHK_DFE];
      chk_mse_en_r <= sweep_active & chk_en[PDCB_CHK_MSE];
      chk_pre_en_r <= sweep_active & chk_en[PDCB_CHK_PRE];
      freqacc_clear_r   <= sweep_iter & freqacc_clr_on;
      dfe_coeff_reset_r <= sweep_iter & dfe_reset_on;
    end
  end

  // Gain, coefficient, timing-loop and energy-detect controls.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gain_map_sel_r        <= 2'h0;
      coeff_set_ls_r        <= 1'b0;
      coeff0_force_r        <= 8'h00;
      coeff0_force_valid_r  <= 1'b0;
      coeff1_force_r        <= 8'h00;
      coeff1_force_valid_r  <= 1'b0;
      eff_kp_r              <= 3'h0;
      eff_kf_r              <= 4'h0;
      prop_arm_hold_r       <= 1'b0;
      integ_arm_hold_r      <= 1'b0;
      ted_pol_invert_r      <= 1'b0;
      precursor_metric_en_r <= 1'b0;
      energy_in_r           <= 10'h000;
    end else begin
      gain_map_sel_r        <= gain_map_nxt;
      coeff_set_ls_r        <= coeff_ls_on;
      coeff0_force_r        <= c0_nxt;
      coeff0_force_valid_r  <= c0_valid_nxt;
      coeff1_force_r        <= c1_short;
      coeff1_force_valid_r  <= c1_valid_nxt;
      eff_kp_r              <= kp_nxt;
      eff_kf_r              <= kf_nxt;
      prop_arm_hold_r  <= arm_hold(prop_arm_hold_on, prop_arm_hold_value,
                                   adapted_prop_hold);
      integ_arm_hold_r <= arm_hold(integ_arm_hold_on, integ_arm_hold_value,
                                   adapted_integ_hold);
      ted_pol_invert_r      <= ted_pol_on;
      precursor_metric_en_r <= precursor_on;
      energy_in_r           <= energy_nxt;
    end
  end

  sequence wr_tloop_s;
    mgmt_wr_en && (mgmt_addr == PDCB_OFS_TLOOP);
  endsequence

  sequence iter_on_s;
    sweep_iter && dfe_reset_on;
  endsequence

  minus_code_a: assert property (tx_symbol == PDCB_SYM_MINUS |=>
      line_drive_code_r == $past(minus_code))
    else $error("minus symbol drive code wrong");
  plus_code_a: assert property (tx_symbol == PDCB_SYM_PLUS |=>
      line_drive_code_r == $past(reg_b[5:0]))
    else $error("plus symbol drive code wrong");
  ffwd_timer_a: assert property (wr_tloop_s or 1'b1 |=>
      first_ffwd_state_timer_r == $past(reg_sw[10:8]))
    else $error("first state timer select not applied");
  ffwd_hold_a: assert property (ffe_state == PDCB_FFE_ST2 |=>
      ffwd_hold_r == $past(reg_sw[6]))
    else $error("second state hold not applied");
  sweep_check_a: assert property (!sweep_active |=>
      !(chk_dfe_en_r || chk_mse_en_r || chk_pre_en_r))
    else $error("metric check enabled outside sweep");
  facc_clear_a: assert property (sweep_iter && !freqacc_clr_on |=>
      !freqacc_clear_r)
    else $error("accumulator cleared while option off");
  dfe_reset_a: assert property (iter_on_s |=> dfe_coeff_reset_r
      ##1 (dfe_coeff_reset_r == $past(sweep_iter && dfe_reset_on)))
    else $error("feedback coefficient reset pulse wrong");
  gain_map_a: assert property (gain_map_sel_r != PDCB_GMAP_BAD)
    else $error("gain map selects a fourth option");
  coeff_long_a: assert property (cable_class == PDCB_CAB_LONG |=>
      coeff0_force_valid_r && coeff0_force_r == $past(reg_c[15:8]))
    else $error("long cable coefficient 0 wrong");
  coeff_short_a: assert property (cable_class == PDCB_CAB_SHORT
      |=> coeff0_force_r == $past(reg_g[8:1]) && coeff1_force_valid_r)
    else $error("short cable coefficient wrong");
  kp_force_a: assert property (prop_gain_override_on |=>
      eff_kp_r == $past(reg_t[13:11]))
    else $error("proportional gain override not applied");
  kf_free_a: assert property (!integ_gain_override_on |=>
      eff_kf_r == $past(adapted_kf))
    else $error("integral gain not adapted");
  prop_hold_a: assert property (prop_arm_hold_on |=>
      prop_arm_hold_r == $past(reg_t[5]))
    else $error("proportional arm hold wrong");
  energy_sel_a: assert property (energy_adc_on |=>
      energy_in_r == $past(adc_dc_free))
    else $error("energy input not converter path");
  tloop_read_a: assert property (wr_tloop_s ##1 (mgmt_rd_en &&
      mgmt_addr == PDCB_OFS_TLOOP) |=> mgmt_rd_valid_r &&
      mgmt_rdata_r[0] == precursor_metric_en_r)
    else $error("pre-cursor enable readback mismatch");
  lvl_b_rsvd_a: assert property (mgmt_rd_en &&
      mgmt_addr == PDCB_OFS_LVL_B |=> mgmt_rdata_r[15:6] == 10'h000)
    else $error("reserved bits read non-zero");

endmodule : pdcb_top

`default_nettype wire

// ---- bench/tb_top.sv ----
/*
  Self-checking bench for the DSP and line-driver configuration bank.
  Assumes the bank's outputs are registered one edge after their causes
  and that a read answers on the edge after the request.
*/
`default_nettype none

module tb_top
  import pdcb_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        mgmt_wr_en = 1'b0;
  logic        mgmt_rd_en = 1'b0;
  logic [15:0] mgmt_addr = 16'h0000;
  logic [15:0] mgmt_wdata = 16'h0000;
  pdcb_sym_e   tx_symbol = PDCB_SYM_ZERO;
  pdcb_ffe_e   ffe_state = PDCB_FFE_OTHER;
  logic        sweep_active = 1'b0;
  logic        sweep_iter = 1'b0;
  pdcb_cable_e cable_class = PDCB_CAB_NONE;
  logic [2:0]  adapted_kp = 3'h0;
  logic [3:0]  adapted_kf = 4'h0;
  logic        adapted_prop_hold = 1'b0;
  logic        adapted_integ_hold = 1'b0;
  logic [9:0]  slicer_in = 10'h000;
  logic [9:0]  adc_dc_free = 10'h000;
  logic [15:0] mgmt_rdata_r;
  logic        mgmt_rd_valid_r;
  logic [5:0]  line_drive_code_r;
  logic [2:0]  first_ffwd_state_timer_r;
  logic        ffwd_hold_r, chk_dfe_en_r, chk_mse_en_r, chk_pre_en_r;
  logic        freqacc_clear_r, dfe_coeff_reset_r, coeff_set_ls_r;
  logic [1:0]  gain_map_sel_r;
  logic [7:0]  coeff0_force_r, coeff1_force_r;
  logic        coeff0_force_valid_r, coeff1_force_valid_r;
  logic [2:0]  eff_kp_r;
  logic [3:0]  eff_kf_r;
  logic        prop_arm_hold_r, integ_arm_hold_r, ted_pol_invert_r;
  logic        precursor_metric_en_r;
  logic [9:0]  energy_in_r;

  pdcb_top i_dut (
    .clk, .reset_n, .mgmt_wr_en, .mgmt_rd_en, .mgmt_addr, .mgmt_wdata,
    .mgmt_rdata_r, .mgmt_rd_valid_r, .tx_symbol, .line_drive_code_r,
    .ffe_state, .first_ffwd_state_timer_r, .ffwd_hold_r, .sweep_active,
    .sweep_iter, .chk_dfe_en_r, .chk_mse_en_r, .chk_pre_en_r,
    .freqacc_clear_r, .dfe_coeff_reset_r, .cable_class, .gain_map_sel_r,
    .coeff_set_ls_r, .coeff0_force_r, .coeff0_force_valid_r,
    .coeff1_force_r, .coeff1_force_valid_r, .adapted_kp, .adapted_kf,
    .adapted_prop_hold, .adapted_integ_hold, .eff_kp_r, .eff_kf_r,
    .prop_arm_hold_r, .integ_arm_hold_r, .ted_pol_invert_r,
    .precursor_metric_en_r, .slicer_in, .adc_dc_free, .energy_in_r);

  // Observed outputs, grouped as the model predicts them.
  wire logic [31:0] g_ld = 32'(line_drive_code_r);
  wire logic [31:0] g_ffe = 32'({first_ffwd_state_timer_r, ffwd_hold_r});
  wire logic [31:0] g_sw = 32'({chk_dfe_en_r, chk_mse_en_r, chk_pre_en_r,
                                freqacc_clear_r, dfe_coeff_reset_r});
  wire logic [31:0] g_gc = 32'({gain_map_sel_r, coeff_set_ls_r,
                                coeff0_force_r, coeff0_force_valid_r,
                                coeff1_force_r, coeff1_force_valid_r});
  wire logic [31:0] g_tl = 32'({eff_kp_r, eff_kf_r, prop_arm_hold_r,
                                integ_arm_hold_r, ted_pol_invert_r,
                                precursor_metric_en_r});
  wire logic [31:0] g_en = 32'(energy_in_r);
  wire logic [31:0] g_rd = 32'({mgmt_rd_valid_r, mgmt_rdata_r});

  int          bad_count = 0;
  int          n_compared = 0;
  int          mr[6] = '{32'h0c00, 32'h0020, 32'h0464,
                         32'h01fc, 32'h06f8, 32'h1101};
  int          msk_v[6] = '{32'h0fff, 32'h003f, 32'h07ff,
                            32'he1fe, 32'hffff, 32'hffff};
  // The last two addresses sit right beside mapped ones and must decode
  // as unmapped.
  logic [15:0] adr_v[8] = '{16'h030b, 16'h030c, 16'h030f, 16'h0311,
                            16'h0313, 16'h031c, 16'h030e, 16'h031d};
  logic [31:0] e_ld, e_ffe, e_sw, e_gc, e_tl, e_en;
  logic [31:0] e_rd = 32'h0;
  logic [31:0] rnd = 32'hd4bb054f;
  int          k;

  always #2.5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic check_all();
    chk(g_ld, e_ld);
    chk(g_ffe, e_ffe);
    chk(g_sw, e_sw);
    chk(g_gc, e_gc);
    chk(g_tl, e_tl);
    chk(g_en, e_en);
    chk(g_rd, e_rd);
  endtask : check_all

  // Predicts the outputs of the coming edge from the inputs just driven,
  // then applies the write that the same edge takes.
  task automatic compute();
    logic       hb;
    logic [1:0] gm;
    logic [7:0] c0;
    case (tx_symbol)
      PDCB_SYM_PLUS:  e_ld = 32'(mr[1][5:0]);
      PDCB_SYM_MINUS: e_ld = 32'(mr[0][11:6]);
      default:        e_ld = 32'(mr[0][5:0]);
    endcase
    hb = (ffe_state == PDCB_FFE_OTHER) ? 1'b0 : mr[2][8 - int'(ffe_state)];
    e_ffe = 32'({mr[2][10:8], hb});
    e_sw = 32'({sweep_active & mr[2][2], sweep_active & mr[2][3],
                sweep_active & mr[2][4], sweep_iter & mr[2][1],
                sweep_iter & mr[2][0]});
    gm = (mr[3][15:14] == 2'h3) ? 2'h0 : mr[3][15:14];
    c0 = (cable_class == PDCB_CAB_LONG) ? mr[4][15:8] : mr[3][8:1];
    e_gc = 32'({gm, mr[3][13], c0,
                cable_class inside {PDCB_CAB_SHORT, PDCB_CAB_LONG},
                mr[4][7:0], cable_class == PDCB_CAB_SHORT});
    e_tl = 32'({mr[5][15] ? mr[5][13:11] : adapted_kp,
                mr[5][14] ? mr[5][10:7] : adapted_kf,
                mr[5][6] ? mr[5][5] : adapted_prop_hold,
                mr[5][4] ? mr[5][3] : adapted_integ_hold,
                mr[5][2], mr[5][0]});
    e_en = 32'(mr[5][1] ? adc_dc_free : slicer_in);
    e_rd[16] = 1'b0;
    if (mgmt_rd_en) begin
      e_rd = 32'({1'b1, (k < 6) ? mr[k][15:0] : 16'h0000});
    end
    if (mgmt_wr_en && k < 6) begin
      mr[k] = int'(mgmt_wdata) & msk_v[k];
    end
  endtask : compute

  initial begin
    repeat (20) @(negedge clk);
    chk(g_ld | g_ffe | g_sw | g_gc | g_tl | g_en | g_rd, 32'h0);
    reset_n = 1'b1;
    @(negedge clk);
    for (int i = 0; i < 3000; i++) begin
      if (i > 0) begin
        check_all();
      end
      rnd = lfsr(rnd);
      k = (i < 8) ? i : int'(rnd[2:0]);
      mgmt_addr = adr_v[k];
      mgmt_rd_en = (i < 8) | rnd[3];
      mgmt_wr_en = (i >= 8) & rnd[4];
      mgmt_wdata = rnd[31:16];
      rnd = lfsr(rnd);
      tx_symbol = pdcb_sym_e'(rnd[1:0]);
      ffe_state = pdcb_ffe_e'(rnd[3:2]);
      sweep_active = rnd[4];
      sweep_iter = rnd[5];
      cable_class = pdcb_cable_e'(rnd[7:6]);
      adapted_kp = rnd[10:8];
      adapted_kf = rnd[14:11];
      adapted_prop_hold = rnd[15];
      adapted_integ_hold = rnd[16];
      slicer_in = rnd[26:17];
      rnd = lfsr(rnd);
      adc_dc_free = rnd[9:0];
      compute();
      @(negedge clk);
    end
    check_all();
    report_and_stop();
  end

  // The sequence needs about 3,030 cycles; this allows over six times that.
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end

endmodule : tb_top

`default_nettype wire
